// ---- core/adcpc_consts.svh ----
// Offsets, field positions, reset values and timing counts of the
// converter power and throughput control block.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
`ifndef ADCPC_CONSTS_SVH
`define ADCPC_CONSTS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define ADCPC_OFS_STATUS   8'h00
`define ADCPC_OFS_RESULT   8'h04
`define ADCPC_OFS_IRQ_STAT 8'h08
`define ADCPC_OFS_IRQ_MASK 8'h0C
`define ADCPC_OFS_CTL_BYTE 8'h10
`define ADCPC_RST_IRQ_MASK 4'h0

// ----------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------
`define ADCPC_EV_DONE  0
`define ADCPC_EV_ABORT 1
`define ADCPC_EV_PWRDN 2
`define ADCPC_EV_WAKE  3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ADCPC_CLK_PERIOD_NS  100
`define ADCPC_T_INT_CONV_NS  3600
`define ADCPC_ACQ_CLKS       3
`define ADCPC_CONV_CLKS      13
`define ADCPC_INT_TICK_CYC \
  ((`ADCPC_T_INT_CONV_NS) / (`ADCPC_CLK_PERIOD_NS * `ADCPC_CONV_CLKS))

`endif

// ---- core/adcpc_pkg.sv ----
// Types shared by the converter control modules.
// Assumes nothing of its surroundings.
`default_nettype none

package adcpc_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ACQ  = 6'h02,
    ST_HOLD = 6'h04,
    ST_CONV = 6'h08,
    ST_STBY = 6'h10,
    ST_SHDN = 6'h20
  } adcpc_state_e;

  typedef logic [11:0] adcpc_code_t;

  typedef struct packed {
    logic       power_ctl_hi;
    logic       power_ctl_lo;
    logic       acq_ext;
    logic [4:0] mux;
  } adcpc_ctl_s;
endpackage

`default_nettype wire

// ---- core/adcpc_if.sv ----
// Carrier between the converter core and its register slave.
// Assumes both ends share one clock.
`default_nettype none

interface adcpc_if;
  import adcpc_pkg::*;
  logic [15:0] status;
  adcpc_code_t result;
  adcpc_ctl_s  ctl;
  logic [3:0]  events;
  logic        irq;

  modport core (output status, result, ctl, events, input irq);
  modport regs (input status, result, ctl, events, output irq);
endinterface

`default_nettype wire

// ---- core/adcpc_sar.sv ----
// Successive-approximation sequencer: twelve trials and a closing step.
// Assumes the comparator output is settled by the next conversion tick.
`default_nettype none
`include "adcpc_consts.svh"

module adcpc_sar #(
  parameter int W = 12
) (
  input  wire logic         clk_in,
  input  wire logic         sys_rst_in,
  input  wire logic         run_in,
  input  wire logic         tick_in,
  input  wire logic         cmp_in,
  output logic [W:0]        dac_out,
  output logic              done_out,
  output logic [W-1:0]      code_out
);
  localparam logic [3:0] NB = 4'(W);

  logic [W-1:0] code_ff;
  logic [3:0]   cnt_ff;
  logic         done_ff;

  wire logic [W-1:0] trial_bit = {1'b1, {(W-1){1'b0}}} >> cnt_ff;
  wire logic [W-1:0] trial     = code_ff | trial_bit;

  // Thresholds sit half a step below each code, in half-step units.
  assign dac_out  = {trial, 1'b0} - (W+1)'(1);
  assign done_out = done_ff;
  assign code_out = code_ff;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !run_in) begin
      code_ff <= '0;
      cnt_ff  <= 4'h0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= tick_in && (cnt_ff == NB);
      if (tick_in && cnt_ff <= NB) begin
        cnt_ff <= cnt_ff + 4'h1;
      end
      if (tick_in && cnt_ff < NB && cmp_in) begin
        code_ff <= trial;
      end
    end
  end
endmodule

`default_nettype wire

// ---- core/adcpc_regs.sv ----
// Avalon-MM slave with status, result, interrupt and mask registers.
// Assumes the master holds its request until waitrequest is low.
`default_nettype none
`include "adcpc_consts.svh"

module adcpc_regs
  import adcpc_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  adcpc_if.regs            rif
);
  logic [3:0]  stat_ff;
  logic [3:0]  mask_ff;
  logic        wait_ff;
  logic        irq_ff;
  logic [31:0] rdata_ff;

  wire logic req      = avs_read_in | avs_write_in;
  wire logic accept   = req & ~wait_ff;
  wire logic sel_stat = avs_address_in == `ADCPC_OFS_STATUS;
  wire logic sel_res  = avs_address_in == `ADCPC_OFS_RESULT;
  wire logic sel_irq  = avs_address_in == `ADCPC_OFS_IRQ_STAT;
  wire logic sel_mask = avs_address_in == `ADCPC_OFS_IRQ_MASK;
  wire logic sel_ctl  = avs_address_in == `ADCPC_OFS_CTL_BYTE;

  wire logic [31:0] rmux =
    sel_stat ? {16'h0000, rif.status} :
    sel_res  ? {20'h00000, rif.result} :
    sel_irq  ? {28'h0000000, stat_ff} :
    sel_mask ? {28'h0000000, mask_ff} :
    sel_ctl  ? {24'h000000, rif.ctl} : 32'h00000000;

  // Only the bits already shown to software are cleared, so an event
  // landing during the read survives it.
  wire logic       clr      = accept & avs_read_in & sel_irq;
  wire logic [3:0] clr_bits = clr ? rdata_ff[3:0] : 4'h0;
  wire logic [3:0] nxt_stat = rif.events | (stat_ff & ~clr_bits);

  assign avs_readdata_out    = rdata_ff;
  assign avs_waitrequest_out = wait_ff;
  assign rif.irq             = irq_ff;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h00000000;
      stat_ff  <= 4'h0;
      mask_ff  <= `ADCPC_RST_IRQ_MASK;
      irq_ff   <= 1'b0;
    end else begin
      wait_ff  <= ~(req & wait_ff);
      rdata_ff <= (req & wait_ff) ? rmux : rdata_ff;
      stat_ff  <= nxt_stat;
      mask_ff  <= (accept & avs_write_in & sel_mask) ? avs_writedata_in[3:0] : mask_ff;
      irq_ff   <= |(nxt_stat & mask_ff);
    end
  end
endmodule

`default_nettype wire

// ---- core/adcpc_top.sv ----
// Power, clock-mode and conversion sequencing of a 12-bit converter
// behind a strobed parallel bus, with an Avalon-MM register view.
// Assumes all pins are synchronous to clk_in and that the external
// conversion clock runs below half of clk_in.
//
// Register access over Avalon-MM and the register addresses were left to the implementer.
`default_nettype none
`include "adcpc_consts.svh"

// Function
// - Power-on reset leaves external clock mode selected and the done line high.
// - Control bits D7 and D6 pick standby or shutdown on a write.
// - Power-down keeps the bus responsive but runs no conversions.
// - Standby returns to full power on the next write strobe rising edge.
// - Shutdown is entered only after the running conversion completes.
// - A write strobe rising edge leaves shutdown and resumes normal work.
// - Output is straight binary, step of reference over 4096, midway transitions.
// - At most 4.8MHz, a cycle is 18 clocks: write, 3 acquire, 13 convert, read.
// - Next byte may be written before reading; previous result stays readable.
// - D7,D6 of 10 selects internal clock, 11 external, else power-down.
// - Selecting power-down keeps the most recently requested clock mode.
// - Done line falls on a ready result; rises on read or byte write.
// - A byte write during conversion aborts it and starts acquisition.
module adcpc_top
  import adcpc_pkg::*;
#(
  parameter logic [1:0] SHDN_CODE = 2'h0,
  parameter int         INT_DIV   = `ADCPC_INT_TICK_CYC
) (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  output logic             irq_out,
  input  wire logic        cs_n_in,
  input  wire logic        wr_n_in,
  input  wire logic        rd_n_in,
  input  wire logic        conv_clk_in,
  input  wire logic [7:0]  data_in,
  output logic [11:0]      data_out,
  output logic             data_oe_out,
  output logic             int_n_out,
  input  wire logic        cmp_in,
  output logic [12:0]      dac_out,
  output logic             track_out,
  output logic [4:0]       mux_cfg_out,
  output logic             analog_en_out,
  output logic             shdn_out
);
  localparam logic [1:0] ACQ_LAST = 2'(`ADCPC_ACQ_CLKS - 1);
  localparam logic [7:0] DIV_LAST = 8'(INT_DIV - 1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  adcpc_state_e st_ff;
  adcpc_state_e nxt_st;
  adcpc_ctl_s   byte_ff;
  adcpc_ctl_s   ctl_ff;
  adcpc_code_t  result_ff;
  logic         wr_low_ff;
  logic         rd_low_ff;
  logic         cclk_ff;
  logic         ext_mode_ff;
  logic [1:0]   acq_cnt_ff;
  logic [7:0]   div_ff;
  logic         int_n_ff;
  logic [11:0]  dout_ff;
  logic         doe_ff;
  logic [12:0]  dac_ff;
  logic         track_ff;
  logic         an_en_ff;
  logic         shdn_ff;
  logic [3:0]   ev_ff;
  logic [12:0]  sar_dac;
  logic         sar_done;
  adcpc_code_t  sar_code;

  adcpc_if rif ();

  // ----------------------------------------------------------------
  // Pin decode
  // ----------------------------------------------------------------
  wire logic wr_act   = ~wr_n_in & ~cs_n_in;
  wire logic rd_act   = ~rd_n_in & ~cs_n_in;
  wire logic wr_rise  = wr_low_ff & wr_n_in;
  wire logic rd_start = rd_act & ~rd_low_ff;

  // Edge detection on a sampled clock pin limits it to below half of
  // clk_in, which still covers the 4.8MHz top conversion rate.
  wire logic ext_tick = conv_clk_in & ~cclk_ff;
  wire logic int_tick = div_ff == DIV_LAST;
  wire logic tick     = ext_mode_ff ? ext_tick : int_tick;

  wire logic is_pd    = (st_ff == ST_STBY) || (st_ff == ST_SHDN);
  wire logic go_shdn  = {ctl_ff.power_ctl_hi, ctl_ff.power_ctl_lo} == SHDN_CODE;
  wire logic acq_end  = tick && (acq_cnt_ff == ACQ_LAST);
  wire logic nxt_pd   = (nxt_st == ST_STBY) || (nxt_st == ST_SHDN);
  wire logic nxt_trk  = (nxt_st == ST_ACQ) || (nxt_st == ST_HOLD);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_ACQ: begin
        if (acq_end) begin
          nxt_st = ST_CONV;
        end
      end
      ST_CONV: begin
        if (sar_done && ctl_ff.power_ctl_hi) begin
          nxt_st = ST_IDLE;
        end else if (sar_done) begin
          // A dummy conversion is how software parks the part.
          nxt_st = go_shdn ? ST_SHDN : ST_STBY;
        end
      end
      ST_IDLE, ST_HOLD, ST_STBY, ST_SHDN: begin
        nxt_st = st_ff;
      end
      default: begin
        nxt_st = ST_IDLE;
      end
    endcase
    if (wr_rise) begin
      // Any write wakes the part and aborts a running conversion.
      if (byte_ff.acq_ext) begin
        nxt_st = ST_HOLD;
      end else if (st_ff == ST_HOLD) begin
        nxt_st = ST_CONV;
      end else begin
        nxt_st = ST_ACQ;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_ff      <= ST_IDLE;
      acq_cnt_ff <= 2'h0;
    end else begin
      st_ff      <= nxt_st;
      acq_cnt_ff <= (st_ff == ST_ACQ && !wr_rise) ? acq_cnt_ff + 2'(tick) : 2'h0;
    end
  end

  // ----------------------------------------------------------------
  // Bus pins and control byte
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wr_low_ff <= 1'b0;
      rd_low_ff <= 1'b0;
      byte_ff   <= '0;
      ctl_ff    <= '0;
    end else begin
      wr_low_ff <= wr_act;
      rd_low_ff <= rd_act;
      byte_ff   <= wr_act ? adcpc_ctl_s'(data_in) : byte_ff;
      ctl_ff    <= wr_rise ? byte_ff : ctl_ff;
    end
  end

  // ----------------------------------------------------------------
  // Conversion clock
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cclk_ff     <= 1'b0;
      div_ff      <= 8'h00;
      ext_mode_ff <= 1'b1;
    end else begin
      cclk_ff <= conv_clk_in;
      div_ff  <= (int_tick || ext_mode_ff) ? 8'h00 : div_ff + 8'h01;
      if (wr_rise && byte_ff.power_ctl_hi) begin
        ext_mode_ff <= byte_ff.power_ctl_lo;
      end
    end
  end

  adcpc_sar #(
    .W (12)
  ) u_sar (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .run_in     (st_ff == ST_CONV),
    .tick_in    (tick),
    .cmp_in     (cmp_in),
    .dac_out    (sar_dac),
    .done_out   (sar_done),
    .code_out   (sar_code)
  );

  // ----------------------------------------------------------------
  // Result, done line and analogue controls
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      result_ff <= 12'h000;
      int_n_ff  <= 1'b1;
      dout_ff   <= 12'h000;
      doe_ff    <= 1'b0;
      dac_ff    <= 13'h0000;
      track_ff  <= 1'b0;
      an_en_ff  <= 1'b1;
      shdn_ff   <= 1'b0;
    end else begin
      // The result only moves on completion, so a read after the next
      // byte write still returns the previous conversion.
      result_ff <= sar_done ? sar_code : result_ff;
      if (sar_done) begin
        int_n_ff <= 1'b0;
      end else if (rd_start || wr_rise) begin
        int_n_ff <= 1'b1;
      end
      dout_ff  <= result_ff;
      doe_ff   <= rd_act;
      dac_ff   <= sar_dac;
      track_ff <= nxt_trk;
      an_en_ff <= !nxt_pd;
      shdn_ff  <= nxt_st == ST_SHDN;
    end
  end

  // ----------------------------------------------------------------
  // Events and register view
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ev_ff <= 4'h0;
    end else begin
      ev_ff[`ADCPC_EV_DONE]  <= sar_done;
      ev_ff[`ADCPC_EV_ABORT] <= wr_rise && (st_ff == ST_CONV) && !sar_done;
      ev_ff[`ADCPC_EV_PWRDN] <= nxt_pd && !is_pd;
      ev_ff[`ADCPC_EV_WAKE]  <= wr_rise && is_pd;
    end
  end

  assign rif.status = {6'h00, ext_mode_ff, shdn_ff, an_en_ff, int_n_ff, st_ff};
  assign rif.result = result_ff;
  assign rif.ctl    = ctl_ff;
  assign rif.events = ev_ff;

  adcpc_regs u_regs (
    .clk_in              (clk_in),
    .sys_rst_in          (sys_rst_in),
    .avs_address_in      (avs_address_in),
    .avs_read_in         (avs_read_in),
    .avs_write_in        (avs_write_in),
    .avs_writedata_in    (avs_writedata_in),
    .avs_readdata_out    (avs_readdata_out),
    .avs_waitrequest_out (avs_waitrequest_out),
    .rif                 (rif)
  );

  assign irq_out       = rif.irq;
  assign data_out      = dout_ff;
  assign data_oe_out   = doe_ff;
  assign int_n_out     = int_n_ff;
  assign dac_out       = dac_ff;
  assign track_out     = track_ff;
  assign mux_cfg_out   = ctl_ff.mux;
  assign analog_en_out = an_en_ff;
  assign shdn_out      = shdn_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  a_por_ext_clock: assert property (
    $past(sys_rst_in) |-> ext_mode_ff && int_n_ff && st_ff == ST_IDLE
  ) else $error("reset did not leave external clock and done high");

  a_pd_select: assert property (
    st_ff == ST_CONV && sar_done && !wr_rise && !ctl_ff.power_ctl_hi
    |=> (st_ff == ST_SHDN) == $past(go_shdn) && st_ff != ST_IDLE
  ) else $error("power-down selection not honoured");

  a_pd_no_conv: assert property (
    is_pd && !wr_rise |=> st_ff == $past(st_ff)
  ) else $error("power-down left without a write");

  a_stby_wake: assert property (
    st_ff == ST_STBY && wr_rise |=> an_en_ff && st_ff != ST_STBY
  ) else $error("standby not left on write");

  a_shdn_entry: assert property (
    $rose(shdn_ff) |-> $past(sar_done) && $past(st_ff) == ST_CONV
  ) else $error("shutdown entered before conversion end");

  a_shdn_wake: assert property (
    st_ff == ST_SHDN && wr_rise |=> !shdn_ff && an_en_ff
  ) else $error("shutdown not left on write");

  a_acq_length: assert property (
    st_ff == ST_ACQ && acq_end && !wr_rise |=> st_ff == ST_CONV
  ) else $error("acquisition did not end after three clocks");

  a_result_hold: assert property (
    $changed(result_ff) |-> $past(sar_done)
  ) else $error("result changed without a completed conversion");

  a_done_low: assert property (
    sar_done |=> !int_n_ff ##1 !int_n_ff || $past(rd_start || wr_rise)
  ) else $error("done line not driven low on completion");

  a_done_release: assert property (
    (rd_start || wr_rise) && !sar_done |=> int_n_ff
  ) else $error("done line not released on read or write");

  a_clk_select: assert property (
    wr_rise && byte_ff.power_ctl_hi |=> ext_mode_ff == $past(byte_ff.power_ctl_lo)
  ) else $error("clock mode not taken from control byte");

  a_clk_keep: assert property (
    wr_rise && !byte_ff.power_ctl_hi |=> $stable(ext_mode_ff)
  ) else $error("clock mode changed on power-down byte");

  a_write_abort: assert property (
    st_ff == ST_CONV && wr_rise |=> st_ff == ST_ACQ || st_ff == ST_HOLD
  ) else $error("write during conversion did not abort it");

  a_int_on_done: assert property (
    $fell(int_n_ff) |-> $past(sar_done)
  ) else $error("done line fell without a completed conversion");

  a_pd_analog_off: assert property (
    is_pd |-> !an_en_ff && !track_ff
  ) else $error("analogue section powered in a power-down state");

  a_shdn_flag: assert property (
    shdn_ff == (st_ff == ST_SHDN)
  ) else $error("shutdown output disagrees with the state");
endmodule

`default_nettype wire

// ---- verification/adcpc_host.sv ----
// Host processor model on the strobed pin bus, plus the analogue input.
// Assumes clk_in is the system clock; the caller sets vin2 in half steps.
`default_nettype none

module adcpc_host (
  input  wire logic        clk_in,
  input  wire logic [12:0] dac_in,
  input  wire logic [11:0] rdata_in,
  input  wire logic        rdata_oe_in,
  output logic             cs_n_out,
  output logic             wr_n_out,
  output logic             rd_n_out,
  output logic [7:0]       byte_out,
  output logic             conv_clk_out,
  output logic             cmp_out
);
  timeunit 1ns;
  timeprecision 1ns;

  int         vin2  = 0;
  logic [1:0] ph_ff = 2'h0;

  // ----------------------------------------------------------------
  // Conversion clock and comparator
  // ----------------------------------------------------------------
  // The conversion clock runs free at a quarter of clk_in, well below
  // the edge-detect limit of the block.
  always @(posedge clk_in) ph_ff <= ph_ff + 2'h1;
  assign conv_clk_out = ph_ff[1];
  assign cmp_out = (vin2 >= int'(dac_in));

  initial begin
    cs_n_out = 1'b1;
    wr_n_out = 1'b1;
    rd_n_out = 1'b1;
    byte_out = 8'hA5;
  end

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Release is aligned to the clock phase so that tick counts are exact.
  task automatic wr_byte(input logic [7:0] b);
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    wr_n_out <= 1'b0;
    byte_out <= b;
    repeat (2) @(posedge clk_in);
    @(posedge clk_in iff ph_ff == 2'h0);
    cs_n_out <= 1'b1;
    wr_n_out <= 1'b1;
    // A released bus floats, so show the inverse rather than stale data.
    byte_out <= ~b;
  endtask

  // The pins are sampled at the last edge of the strobe, where the
  // registered data and its enable have settled.
  task automatic rd_res(output logic [12:0] d);
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    rd_n_out <= 1'b0;
    repeat (3) @(posedge clk_in);
    d = {rdata_oe_in, rdata_in};
    cs_n_out <= 1'b1;
    rd_n_out <= 1'b1;
  endtask
endmodule

`default_nettype wire

// ---- verification/adcpc_top_tb_top.sv ----
// Self-checking bench for the converter power and throughput control.
// Assumes the host model drives the pin bus and the bench the register bus.
`default_nettype none
`include "adcpc_consts.svh"

module adcpc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [7:0]  avs_address_in = 8'h00;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out, irq_out, cs_n_in, wr_n_in, rd_n_in, conv_clk_in;
  logic [7:0]  data_in;
  logic [11:0] data_out;
  logic        data_oe_out, int_n_out, cmp_in, track_out, analog_en_out, shdn_out;
  logic [12:0] dac_out;
  logic [4:0]  mux_cfg_out;
  int          num_errors = 0;
  int          checks_done = 0;
  int          tick_cnt = 0;
  int          exp_q[$];
  int          edge_v[5] = '{0, 1, 2, 8190, 8191};
  logic        cc_q = 1'b0;
  logic [15:0] lf = 16'h0009;

  adcpc_top #(.SHDN_CODE(2'h0), .INT_DIV(2)) adcpc_top_inst (.*);

  adcpc_host adcpc_host_inst (.clk_in(clk_in), .dac_in(dac_out), .rdata_in(data_out),
    .rdata_oe_in(data_oe_out), .cs_n_out(cs_n_in),
    .wr_n_out(wr_n_in), .rd_n_out(rd_n_in), .byte_out(data_in),
    .conv_clk_out(conv_clk_in), .cmp_out(cmp_in));

  initial forever #50 clk_in = ~clk_in;

  always @(posedge clk_in) begin
    cc_q <= conv_clk_in;
    if (conv_clk_in && !cc_q) tick_cnt <= tick_cnt + 1;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic av(input bit wr, input logic [7:0] a, input logic [31:0] wd,
                    output logic [31:0] rd);
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= wd;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    // Only the watchdog ends a request that is never answered.
    do begin
      @(posedge clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask

  function automatic int next_v();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return int'(lf[12:0]);
  endfunction

  // The model: straight binary, half-step transitions, clipped at full scale.
  task automatic start(input logic [7:0] b, input int v, input bit keep);
    adcpc_host_inst.vin2 <= v;
    if (keep) exp_q.push_back((v >= 8191) ? 4095 : (v + 1) / 2);
    adcpc_host_inst.wr_byte(b);
  endtask

  task automatic wait_ticks(input int k);
    int t0;
    t0 = tick_cnt;
    while (tick_cnt - t0 < k) @(posedge clk_in);
  endtask

  task automatic wait_done(output int t);
    int t0, n;
    t0 = tick_cnt;
    n = 0;
    while (int_n_out !== 1'b0 && n < 2000) begin
      @(posedge clk_in);
      n++;
    end
    t = tick_cnt - t0;
    if (n >= 2000) chk(32'h0, 32'h1);
  endtask

  task automatic result_check();
    logic [12:0] d;
    logic [31:0] r;
    int          e;
    e = exp_q.pop_front();
    adcpc_host_inst.rd_res(d);
    chk(d[11:0], e);
    chk(d[12], 1'b1);
    chk(int_n_out, 1'b1);
    av(0, `ADCPC_OFS_RESULT, 0, r);
    chk(r, e);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk_in);
    num_errors++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    int          t, v;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk(int_n_out, 1'b1);
    av(0, `ADCPC_OFS_STATUS, 0, r);
    chk(r, 32'h2C1);
    av(0, `ADCPC_OFS_IRQ_MASK, 0, r);
    chk(r, 32'h0);
    av(1, `ADCPC_OFS_IRQ_MASK, 32'hF, r);
    av(0, `ADCPC_OFS_IRQ_MASK, 0, r);
    chk(r, 32'hF);
    av(1, `ADCPC_OFS_IRQ_MASK, 32'h0, r);
    av(0, 8'h20, 0, r);
    chk(r, 32'h0);
    // Reset interval and reference settling, both well covered here.
    repeat (5000) @(posedge clk_in);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      v = (i < 5) ? edge_v[i] : next_v();
      start(8'hC0, v, 1'b1);
      wait_done(t);
      chk(t, 16);
      result_check();
    end
    // External acquisition: track until a second write starts conversion.
    start(8'hE0, next_v(), 1'b1);
    repeat (2) @(posedge clk_in);
    chk(track_out, 1'b1);
    adcpc_host_inst.wr_byte(8'hC0);
    wait_done(t);
    chk(t, `ADCPC_CONV_CLKS);
    result_check();
    chk(irq_out, 1'b0);
    av(0, `ADCPC_OFS_CTL_BYTE, 0, r);
    chk(r, 32'hC0);
    $display("test external clock done");
    start(8'h80, next_v(), 1'b1);
    wait_done(t);
    result_check();
    av(0, `ADCPC_OFS_STATUS, 0, r);
    chk(r & 32'h200, 32'h0);
    start(8'h80, next_v(), 1'b1);
    wait_done(t);
    start(8'h80, next_v(), 1'b1);
    repeat (2) @(posedge clk_in);
    chk(int_n_out, 1'b1);
    result_check();
    wait_done(t);
    result_check();
    $display("test internal and overlap done");
    // Dummy conversion into standby.
    start(8'h40, next_v(), 1'b1);
    wait_done(t);
    result_check();
    av(0, `ADCPC_OFS_STATUS, 0, r);
    chk(r, 32'h050);
    repeat (200) @(posedge clk_in);
    chk(track_out, 1'b0);
    chk(int_n_out, 1'b1);
    av(0, `ADCPC_OFS_IRQ_STAT, 0, r);
    chk(r[2], 1'b1);
    start(8'hC3, next_v(), 1'b1);
    repeat (2) @(posedge clk_in);
    chk(analog_en_out, 1'b1);
    chk(mux_cfg_out, 5'h03);
    wait_done(t);
    result_check();
    $display("test standby done");
    start(8'h00, next_v(), 1'b1);
    wait_ticks(8);
    chk(shdn_out, 1'b0);
    chk(analog_en_out, 1'b1);
    wait_done(t);
    result_check();
    av(0, `ADCPC_OFS_STATUS, 0, r);
    chk(r, 32'h360);
    repeat (500) @(posedge clk_in);
    start(8'h40, next_v(), 1'b1);
    repeat (2) @(posedge clk_in);
    chk(shdn_out, 1'b0);
    wait_done(t);
    result_check();
    $display("test shutdown done");
    av(1, `ADCPC_OFS_IRQ_MASK, 32'h2, r);
    av(0, `ADCPC_OFS_IRQ_STAT, 0, r);
    start(8'hC0, next_v(), 1'b0);
    wait_ticks(8);
    start(8'hC0, next_v(), 1'b1);
    repeat (4) @(posedge clk_in);
    chk(irq_out, 1'b1);
    wait_done(t);
    result_check();
    av(0, `ADCPC_OFS_IRQ_STAT, 0, r);
    chk(r, 32'hB);
    repeat (2) @(posedge clk_in);
    chk(irq_out, 1'b0);
    $display("test abort done");
    end_of_test();
  end
endmodule

`default_nettype wire
